// File: shared/current_ref_pkg.sv
// constants for the programmable current reference control block
// assumes an 8-bit special-function bus with page select on the core side
package current_ref_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ctrl_addr     = 8'hb9;
  localparam logic [3:0] ctrl_page     = 4'h0;
  localparam logic [3:0] cfg_page      = 4'hf;
  localparam logic [7:0] ctrl_reset    = 8'h00;
  localparam logic [7:0] cfg_reset     = 8'h00;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int sink_bit              = 7;
  localparam int range_bit             = 6;
  localparam int count_msb             = 5;
  localparam int enable_bit            = 7;
  localparam int source_msb            = 2;
  localparam int num_outputs           = 6;
  localparam logic [7:0] cfg_rd_mask   = 8'h87;
  localparam logic [2:0] source_max    = 3'h5;

  // ----------------------------------------------------------------
  // step weights in microamps; cell weight in count steps
  // ----------------------------------------------------------------
  localparam logic [3:0] step_low_ua   = 4'h1;
  localparam logic [3:0] step_high_ua  = 4'h8;
  localparam logic [5:0] count_zero    = 6'h00;
  localparam logic [6:0] cell_weight   = 7'h02;
  localparam logic [7:0] rdata_idle    = 8'h00;

endpackage

// File: logic/compare_output_select.sv
// selector of one timer compare output for the fine-tune cell
// assumes compare outputs are synchronous to ref_clk
`timescale 1ns/100ps
module compare_output_select (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [5:0] compare_output,
  input  wire logic [2:0] fine_tune_source_select,
  input  wire logic       fine_tune_enable,
  output logic            fine_tune_gate
);

  // ----------------------------------------------------------------
  // selection
  // ----------------------------------------------------------------
  // reserved codes pick nothing, so the cell stays off
  wire        code_ok  = fine_tune_source_select <=
                         current_ref_pkg::source_max;
  wire        selected = code_ok ?
                         compare_output[fine_tune_source_select] : 1'b0;
  wire        gate_d   = fine_tune_enable & selected;

  logic       gate_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= gate_d;
    end
  end

  assign fine_tune_gate = gate_q;

  a_gate_off_disabled: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !fine_tune_enable |=> !fine_tune_gate)
    else $error("fine-tune gate active while disabled");

endmodule // compare_output_select

// File: logic/current_ref_control.sv
// register pair and output decode of the programmable current reference
// assumes a single-cycle special-function bus and page register from core
`timescale 1ns/100ps
module current_ref_control (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [3:0] sfr_page,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  output logic            sfr_hit,
  input  wire logic [5:0] compare_output,
  output logic            sink_enable,
  output logic            high_range,
  output logic      [5:0] step_count,
  output logic            current_reference_active,
  output logic      [3:0] step_size_ua,
  output logic            fine_tune_gate,
  output logic signed [10:0] target_current_ua
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [3:0] p,
                               input logic [3:0] want);
    hit = (a == current_ref_pkg::ctrl_addr) && (p == want);
  endfunction

  wire sel_ctrl = hit(sfr_addr, sfr_page, current_ref_pkg::ctrl_page);
  wire sel_cfg  = hit(sfr_addr, sfr_page, current_ref_pkg::cfg_page);
  wire wr_ctrl  = sfr_wr & sel_ctrl;
  wire wr_cfg   = sfr_wr & sel_cfg;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  assign ctrl_d  = wr_ctrl ? sfr_wdata : ctrl_q;
  // unused bits never store, so they cannot leak into readback
  assign cfg_d   = wr_cfg ? (sfr_wdata & current_ref_pkg::cfg_rd_mask)
                          : cfg_q;
  assign rdata_d = !sfr_rd  ? rdata_q :
                   sel_ctrl ? ctrl_q :
                   sel_cfg  ? cfg_q : current_ref_pkg::rdata_idle;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_q  <= current_ref_pkg::ctrl_reset;
      cfg_q   <= current_ref_pkg::cfg_reset;
      rdata_q <= current_ref_pkg::rdata_idle;
    end else begin
      ctrl_q  <= ctrl_d;
      cfg_q   <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  assign sfr_rdata = rdata_q;
  assign sfr_hit   = sel_ctrl | sel_cfg;

  // ----------------------------------------------------------------
  // analog controls
  // ----------------------------------------------------------------
  wire       fine_en = cfg_q[current_ref_pkg::enable_bit];
  wire [2:0] src     = cfg_q[current_ref_pkg::source_msb:0];

  assign sink_enable  = ctrl_q[current_ref_pkg::sink_bit];
  assign high_range   = ctrl_q[current_ref_pkg::range_bit];
  assign step_count   = ctrl_q[current_ref_pkg::count_msb:0];
  assign step_size_ua = high_range ? current_ref_pkg::step_high_ua
                                   : current_ref_pkg::step_low_ua;
  // reference biased only for a non-zero count
  assign current_reference_active =
    (step_count != current_ref_pkg::count_zero);

  // ideal magnitude for the analog trim model; cell adds two lsbs
  wire [9:0] magnitude = 10'(step_count) * 10'(step_size_ua);
  assign target_current_ua = sink_enable ? -11'(signed'({1'b0, magnitude}))
                                         : 11'(signed'({1'b0, magnitude}));

  // ----------------------------------------------------------------
  // fine-tune cell
  // ----------------------------------------------------------------
  // step total seen with the cell held fully on; the analog side
  // averages the gate, so partial duty lands between the two codes
  wire [6:0] cell_steps = fine_tune_gate ? current_ref_pkg::cell_weight
                                         : 7'h00;
  wire [6:0] trim_steps = {1'b0, step_count} + cell_steps;

  // two-lsb cell weight: full duty on 00b equals count code 10b
  compare_output_select u_select (
    .ref_clk                 (ref_clk),
    .rst_n                   (rst_n),
    .compare_output          (compare_output),
    .fine_tune_source_select (src),
    .fine_tune_enable        (fine_en),
    .fine_tune_gate          (fine_tune_gate)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_ctrl_write_page: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (sfr_wr && sfr_addr == current_ref_pkg::ctrl_addr &&
     sfr_page == current_ref_pkg::ctrl_page) |=>
    ctrl_q == $past(sfr_wdata))
    else $error("control write on page 0 not stored");

  a_cfg_write_page: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (sfr_wr && sfr_addr == current_ref_pkg::ctrl_addr &&
     sfr_page == current_ref_pkg::cfg_page) |=>
    cfg_q == ($past(sfr_wdata) & current_ref_pkg::cfg_rd_mask))
    else $error("config write on page f not stored");

  a_ctrl_other_page: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (sfr_page != current_ref_pkg::ctrl_page) |=> $stable(ctrl_q))
    else $error("control changed from another page");

  a_cfg_other_page: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (sfr_page != current_ref_pkg::cfg_page) |=> $stable(cfg_q))
    else $error("config changed from another page");

  a_other_addr: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (sfr_addr != current_ref_pkg::ctrl_addr) |=>
    ($stable(ctrl_q) && $stable(cfg_q)))
    else $error("register changed from another address");

  a_hit_decode: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    sfr_hit == (sfr_addr == current_ref_pkg::ctrl_addr &&
                (sfr_page == current_ref_pkg::ctrl_page ||
                 sfr_page == current_ref_pkg::cfg_page)))
    else $error("register hit decode wrong");

  a_read_ctrl: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (sfr_rd && sel_ctrl) |=> sfr_rdata == $past(ctrl_q))
    else $error("control readback wrong");

  a_read_cfg: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (sfr_rd && sel_cfg) |=> sfr_rdata == $past(cfg_q))
    else $error("config readback wrong");

  a_read_unmapped: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (sfr_rd && !sfr_hit) |=> sfr_rdata == current_ref_pkg::rdata_idle)
    else $error("unmapped read not zero");

  a_rdata_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");

  a_unused_zero: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (cfg_q & ~current_ref_pkg::cfg_rd_mask) == '0)
    else $error("unused config bits not zero");

  a_direction_bit: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    sink_enable == (target_current_ua < 0) ||
    step_count == current_ref_pkg::count_zero)
    else $error("direction does not follow sink bit");

  a_step_product: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (sink_enable ? -target_current_ua : target_current_ua) ==
    11'(step_count) * 11'(step_size_ua))
    else $error("target current not count times step");

  a_step_size: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    step_size_ua == (ctrl_q[current_ref_pkg::range_bit] ?
                     current_ref_pkg::step_high_ua :
                     current_ref_pkg::step_low_ua))
    else $error("step size wrong for range");

  a_low_power: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    current_reference_active ==
    (ctrl_q[current_ref_pkg::count_msb:0] != current_ref_pkg::count_zero))
    else $error("reference active state wrong for count");

  a_gate_follows: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (fine_en && src <= current_ref_pkg::source_max) |=>
    fine_tune_gate == $past(compare_output[src]))
    else $error("gate does not follow selected output");

  a_reserved_off: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (src > current_ref_pkg::source_max) |=> !fine_tune_gate)
    else $error("reserved select drove the gate");

  a_cell_weight: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (fine_tune_gate && step_count[1:0] == 2'h0) |->
    trim_steps == {1'b0, step_count[current_ref_pkg::count_msb:2], 2'h2})
    else $error("full-duty cell does not equal code 10b");

endmodule // current_ref_control

// File: sim/sfr_core_model.sv
// core side of the special-function bus
// assumes tasks are entered at a rising ref_clk edge
`timescale 1ns/100ps
module sfr_core_model (
  input  wire logic       ref_clk,
  output logic      [7:0] sfr_addr,
  output logic      [3:0] sfr_page,
  output logic            sfr_wr,
  output logic            sfr_rd,
  output logic      [7:0] sfr_wdata,
  input  wire logic [7:0] sfr_rdata,
  input  wire logic       sfr_hit
);
  initial begin
    sfr_addr = 8'h00;
    sfr_page = 4'h0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
  end
  // idle edge after each strobe: no double assign on back to back
  task automatic wr(input logic [3:0] pg, input logic [7:0] ad,
                    input logic [7:0] d);
    sfr_page <= pg;
    sfr_addr <= ad;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
    sfr_wdata <= ~d;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] pg, input logic [7:0] ad,
                    output logic [7:0] d, output logic h);
    sfr_page <= pg;
    sfr_addr <= ad;
    sfr_rd <= 1'b1;
    @(posedge ref_clk);
    h = sfr_hit;
    sfr_rd <= 1'b0;
    @(posedge ref_clk);
    d = sfr_rdata;
  endtask
endmodule // sfr_core_model

// File: sim/tb_top.sv
// self-checking bench for the current reference control
// assumes the core model drives the register bus
`timescale 1ns/100ps
module tb_top;
  logic        ref_clk, rst_n, wr, rd, hit, hs, sink, hi, act, gate;
  logic [7:0]  addr, wdata, rdata, r8;
  logic [3:0]  page, ssz;
  logic [5:0]  cnt, cmp;
  logic [10:0] tgt;
  logic [31:0] seed;
  int          errors, n_tests;
  localparam logic [7:0] corner [4] = '{8'hff, 8'h80, 8'h7f, 8'h00};
  current_ref_control dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .sfr_addr(addr), .sfr_page(page), .sfr_wr(wr), .sfr_rd(rd),
    .sfr_wdata(wdata), .sfr_rdata(rdata), .sfr_hit(hit),
    .compare_output(cmp), .sink_enable(sink), .high_range(hi),
    .step_count(cnt), .current_reference_active(act),
    .step_size_ua(ssz), .fine_tune_gate(gate), .target_current_ua(tgt));
  sfr_core_model core (.ref_clk(ref_clk), .sfr_addr(addr),
    .sfr_page(page), .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata),
    .sfr_rdata(rdata), .sfr_hit(hit));
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [10:0] exp_tgt(input logic [7:0] c);
    logic [10:0] m;
    m = {5'h00, c[5:0]} * (c[6] ? 11'h008 : 11'h001);
    return c[7] ? -m : m;
  endfunction
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic ctrl_case(input logic [7:0] v);
    core.wr(4'h0, 8'hb9, v);
    chk(sink, v[7]);
    chk(hi, v[6]);
    chk(ssz, v[6] ? 11'h008 : 11'h001);
    chk(cnt, v[5:0]);
    chk(tgt, exp_tgt(v));
    chk(act, v[5:0] != 6'h00);
    core.rd(4'h0, 8'hb9, r8, hs);
    chk(r8, v);
    chk(hs, 1'b1);
  endtask
  task automatic cfg_case(input logic [7:0] v, input logic [5:0] c);
    core.wr(4'hf, 8'hb9, v);
    core.rd(4'hf, 8'hb9, r8, hs);
    chk(r8, v & 8'h87);
    chk(hs, 1'b1);
    cmp <= c;
    @(posedge ref_clk);
    @(posedge ref_clk);
    chk(gate, v[7] && v[2:0] <= 3'h5 && c[v[2:0]]);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    errors++;
    finish_test();
  end
  initial begin
    errors = 0;
    n_tests = 0;
    seed = 32'h00000022;
    rst_n = 1'b0;
    cmp = 6'h00;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    core.rd(4'hf, 8'hb9, r8, hs);
    chk(r8, 8'h00);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      ctrl_case(i < 4 ? corner[i] : seed[7:0]);
    end
    ctrl_case(8'h4c);
    for (int i = 0; i < 32; i++) begin
      seed = xs(seed);
      cfg_case({i[3], seed[6:3], i[2:0]}, seed[13:8]);
    end
    ctrl_case(8'h15);
    core.wr(4'h3, 8'hb9, 8'hff);
    core.wr(4'h0, 8'hb8, 8'hff);
    chk(cnt, 6'h15);
    core.rd(4'h3, 8'hb9, r8, hs);
    chk(hs, 1'b0);
    chk(r8, 8'h00);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk(cnt, 6'h00);
    chk(act, 1'b0);
    chk(gate, 1'b0);
    core.rd(4'h0, 8'hb9, r8, hs);
    chk(r8, 8'h00);
    core.rd(4'hf, 8'hb9, r8, hs);
    chk(r8, 8'h00);
    finish_test();
  end
endmodule // tb_top
